// ---- bench/buc_feed_model.sv ----
// Up-converter feed model: reports cable voltage and current
`timescale 1ns/100ps
`default_nettype none
module buc_feed_model
  import mod_alarm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Feed switch and load set-up
  input wire logic feedOn,
  input wire logic [9:0] setVolt,
  input wire logic [9:0] setCurr,
  // Readings
  output var feedMeas_t meas
);
  // Unpowered cable reads zero, never the last value
  always_ff @(posedge clk) begin
    meas <= feedOn ? feedMeas_t'({1'b1, setVolt, setCurr}) : feedMeas_t'(21'h0);
  end
endmodule
`default_nettype wire

// ---- bench/mod_alarm_checker.sv ----
// Checker: port-level properties of the alarm routing block
`timescale 1ns/100ps
`default_nettype none
module mod_alarm_checker
  import mod_alarm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic write,
  // Alarm side
  input wire faults_t faults,
  input wire alarmReq_t alarmOut,
  input wire logic feedOn,
  input wire testMode_t testMode,
  // Clock selection
  input wire logic ttClkPresent,
  input wire logic rcvClkPresent,
  input wire clkSrc_t txClkSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Assertions
  // ****************************************
  carrier_mute_a: assert property (faults.carrier |=> alarmOut.mute)
    else $error("carrier fault did not mute");
  hw_mute_a: assert property (faults.hardware |=> alarmOut.mute)
    else $error("hardware fault did not mute");
  ones_cause_a: assert property (alarmOut.allOnes |-> $past(faults.clock))
    else $error("all ones without clock fault");
  alarm_cause_a: assert property ($rose(alarmOut.alarmA) |-> $past(|faults) || feedOn)
    else $error("alarm A rose with no source");
  // Write excluded: feed bit leads its output by a cycle
  quiet_out_a: assert property ((faults == '0 && !feedOn && !write)[*3] |=> alarmOut == '0)
    else $error("alarm outputs without fault");
  tt_fallback_a: assert property (txClkSel == CLK_TT |-> $past(ttClkPresent))
    else $error("absent TT clock selected");
  rcv_fallback_a: assert property (txClkSel == CLK_RCV |-> $past(rcvClkPresent))
    else $error("absent receive clock selected");
  feed_write_a: assert property ($changed(feedOn) |-> $past(write) || $past(write, 2))
    else $error("feed switched without write");
  test_write_a: assert property ($changed(testMode) |-> $past(write) || $past(write, 2))
    else $error("test mode changed without write");
  ones_c: cover property (alarmOut.allOnes);
  mute_a_c: cover property (alarmOut.mute && alarmOut.alarmA);
  rcv_c: cover property (txClkSel == CLK_RCV);
endmodule
`default_nettype wire

// ---- bench/tb_mod_alarm_routing.sv ----
// Testbench of the alarm routing block
`timescale 1ns/100ps
`default_nettype none
module tb_mod_alarm_routing;
  import mod_alarm_pkg::*;
  logic clk, rst_n, read, write, waitrequest, irq, bitTick;
  logic ttClkPresent, extClkPresent, rcvClkPresent, feedOn, refOn, rfFreqMode;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rdVal;
  logic [9:0] setVolt, setCurr;
  logic [1:0] tickCnt;
  faults_t faults;
  feedMeas_t feedMeas;
  alarmReq_t alarmOut;
  testMode_t testMode;
  clkSrc_t txClkSel;
  int mismatches, numChecks;
  mod_alarm_routing #(.MEAS_WIN(100)) DUT (.clk, .rst_n, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .irq, .faults, .feedMeas, .ttClkPresent,
    .extClkPresent, .rcvClkPresent, .bitTick, .alarmOut, .feedOn, .refOn, .rfFreqMode,
    .testMode, .txClkSel);
  buc_feed_model FEED (.clk, .feedOn, .setVolt, .setCurr, .meas(feedMeas));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Four-cycle bit clock: 25 ticks per 100-cycle window
  always @(posedge clk) begin
    if (!rst_n) begin
      tickCnt <= 2'h0;
      bitTick <= 1'b0;
    end else begin
      tickCnt <= tickCnt + 2'h1;
      bitTick <= (tickCnt == 2'h3);
    end
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bw(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic br(input logic [5:0] a);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rdVal = readdata;
    read <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_config();
    for (int m = 0; m < 4; m++) begin
      bw(ADDR_CTRL, 32'(m * 5));
      cyc(3);
      chk({28'h0, testMode, refOn, feedOn}, 32'(m * 5));
    end
    for (int v = 1; v >= 0; v--) begin
      bw(ADDR_LOFREQ, v ? 32'h80000000 : 32'h0);
      cyc(3);
      chk(32'(rfFreqMode), 32'(v));
    end
  endtask
  task automatic t_clock();
    for (int s = 1; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        bw(ADDR_CTRL, 32'(s) << 4);
        {rcvClkPresent, extClkPresent, ttClkPresent} <= 3'(p << (s - 1));
        cyc(3);
        chk(32'(txClkSel), p ? 32'(s) : 32'h0);
      end
    end
    bw(ADDR_CTRL, 32'h0);
  endtask
  task automatic rt(input int sh, input int fb, input int code, input logic [3:0] e);
    bw(ADDR_ROUTE, 32'(code) << sh);
    faults <= faults_t'(6'h01 << fb);
    cyc(3);
    chk(32'(alarmOut), {28'h0, e});
    faults <= '0;
    cyc(3);
  endtask
  task automatic t_route();
    logic [3:0] e;
    for (int c = 0; c < 16; c++) begin
      e = c < 4 ? {c[0], c[1], 2'b00} : c < 8 ? {c[0], c[1], 2'b01} : 4'h0;
      e = c == 8 ? 4'h2 : c == 9 ? 4'ha : e;
      rt(4, 3, c, e);
      if (c < 4) begin
        rt(2, 4, c, {c[0], c[1], 2'b00});
        rt(8, 2, c, {c[0], c[1], 2'b00});
        rt(10, 1, c, {c[0], c[1], 2'b00});
        rt(0, 5, c, {c[0], c[1], 2'b10});
        rt(12, 0, c, {c[0], c[1], 2'b10});
      end
    end
    bw(ADDR_ROUTE, 32'h204);
    faults <= faults_t'(6'h14);
    cyc(3);
    chk(32'(alarmOut), 32'hc);
    faults <= faults_t'(6'h04);
    cyc(3);
    chk(32'(alarmOut), 32'h4);
    faults <= '0;
  endtask
  task automatic t_buc();
    logic [9:0] v[5] = '{238, 199, 238, 238, 200};
    logic [9:0] c[5] = '{237, 237, 501, 124, 500};
    bw(ADDR_VMIN, 32'h3ff);
    br(ADDR_VMIN);
    chk(rdVal, 32'h258);
    bw(ADDR_IMAX, 32'h3ff);
    br(ADDR_IMAX);
    chk(rdVal, 32'h258);
    bw(ADDR_IMIN, 32'h3ff);
    br(ADDR_IMIN);
    chk(rdVal, 32'h190);
    bw(ADDR_VMIN, 32'd200);
    bw(ADDR_IMAX, 32'd500);
    bw(ADDR_IMIN, 32'd125);
    bw(ADDR_CTRL, 32'h1);
    setVolt <= 10'd199;
    for (int k = 0; k < 8; k++) begin
      bw(ADDR_ROUTE, 32'(k) << 14);
      cyc(4);
      chk(32'(alarmOut), {28'h0, k[0], k[1], k[2], 1'b0});
    end
    for (int k = 0; k < 5; k++) begin
      setVolt <= v[k];
      setCurr <= c[k];
      cyc(4);
      chk(32'(alarmOut), (k > 0 && k < 4) ? 32'he : 32'h0);
      if (k == 1) begin
        br(ADDR_STATUS);
        chk(rdVal, 32'h3e);
        br(ADDR_MEAS);
        chk(rdVal, 32'h00ed00c7);
      end
    end
    bw(ADDR_CTRL, 32'h0);
    cyc(4);
    chk(32'(alarmOut), 32'h0);
  endtask
  task automatic t_irq();
    bw(ADDR_IRQMASK, 32'h0);
    bw(ADDR_ROUTE, 32'h4);
    br(ADDR_IRQSTAT);
    for (int m = 0; m < 2; m++) begin
      bw(ADDR_IRQMASK, 32'(m));
      faults <= faults_t'(6'h10);
      cyc(3);
      chk(32'(irq), 32'(m));
      br(ADDR_IRQSTAT);
      chk(rdVal, 32'h1);
      cyc(3);
      chk(32'(irq), 32'h0);
      faults <= '0;
      cyc(3);
    end
  endtask
  task automatic t_rates();
    logic [31:0] cr[3] = '{32'h700, 32'h7c0, 32'h0};
    logic [31:0] sr[3] = '{32'd500000, 32'd285714, 32'd1000000};
    bw(ADDR_BITRATE, 32'd1000000);
    for (int k = 0; k < 3; k++) begin
      bw(ADDR_CTRL, cr[k]);
      cyc(100);
      br(ADDR_SYMRATE);
      chk(rdVal, sr[k]);
    end
    for (int k = 0; k < 2; k++) begin
      bw(ADDR_BITRATE, k ? 32'd26000 : 32'd24000);
      cyc(250);
      br(ADDR_CLKERR);
      chk(rdVal, k ? 32'hfffffc18 : 32'd1000);
    end
  endtask
  initial begin
    {rst_n, read, write, ttClkPresent, extClkPresent, rcvClkPresent} = '0;
    {address, writedata} = '0;
    faults = '0;
    setVolt = 10'd238;
    setCurr = 10'd237;
    cyc(10);
    rst_n <= 1'b1;
    br(ADDR_IMAX);
    chk(rdVal, 32'h258);
    br(6'h3c);
    chk(rdVal, 32'h0);
    t_config();
    t_clock();
    t_route();
    t_irq();
    t_buc();
    t_rates();
    tally_and_finish();
  end
  // Whole run needs about 1400 cycles
  initial begin
    cyc(20000);
    mismatches++;
    tally_and_finish();
  end
endmodule
bind mod_alarm_routing mod_alarm_checker chkInst (.clk, .rst_n, .write, .faults, .alarmOut,
  .feedOn, .testMode, .ttClkPresent, .rcvClkPresent, .txClkSel);
`default_nettype wire

// ---- common/mod_alarm_pkg.sv ----
// Package: register map, field layout and types of the modulator alarm block
package mod_alarm_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_ROUTE = 6'h04;
  localparam logic [5:0] ADDR_VMIN = 6'h08;
  localparam logic [5:0] ADDR_IMAX = 6'h0c;
  localparam logic [5:0] ADDR_IMIN = 6'h10;
  localparam logic [5:0] ADDR_LOFREQ = 6'h14;
  localparam logic [5:0] ADDR_BITRATE = 6'h18;
  localparam logic [5:0] ADDR_STATUS = 6'h1c;
  localparam logic [5:0] ADDR_SYMRATE = 6'h20;
  localparam logic [5:0] ADDR_CLKERR = 6'h24;
  localparam logic [5:0] ADDR_MEAS = 6'h28;
  localparam logic [5:0] ADDR_IRQSTAT = 6'h2c;
  localparam logic [5:0] ADDR_IRQMASK = 6'h30;

  // ****************************************
  // Field limits and reset values
  // ****************************************
  localparam int MEAS_W = 10;
  localparam logic [9:0] VMIN_MAX = 10'h258;  // 60.0 V in 0.1 V steps
  localparam logic [9:0] IMAX_MAX = 10'h258;  // 6.00 A in 0.01 A steps
  localparam logic [9:0] IMIN_MAX = 10'h190;  // 4.00 A in 0.01 A steps
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [16:0] ROUTE_RST = 17'h00000;
  localparam int NUM_IRQ = 5;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    TEST_NORMAL = 2'b00,
    TEST_PURE = 2'b01,
    TEST_ALT10 = 2'b10,
    TEST_SIDEBAND = 2'b11
  } testMode_t;

  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'b00,
    CLK_TT = 2'b01,
    CLK_EXTERNAL = 2'b10,
    CLK_RCV = 2'b11
  } clkSrc_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic carrier;
    logic data;
    logic clock;
    logic aupc;
    logic testActive;
    logic hardware;
  } faults_t;

  typedef struct packed {
    logic present;
    logic [9:0] volt;
    logic [9:0] curr;
  } feedMeas_t;

  typedef struct packed {
    logic alarmA;
    logic alarmB;
    logic mute;
    logic allOnes;
  } alarmReq_t;

  typedef struct packed {
    logic [2:0] buc;
    logic [1:0] hardware;
    logic [1:0] testActive;
    logic [1:0] aupc;
    logic [3:0] clock;
    logic [1:0] data;
    logic [1:0] carrier;
  } route_t;

  typedef struct packed {
    logic fecOn;
    logic [1:0] modBits;
    logic [1:0] codeRate;
    logic [1:0] clkSrc;
    logic [1:0] testMode;
    logic refOn;
    logic feedOn;
  } ctrl_t;

endpackage

// ---- src/mod_alarm_routing.sv ----
// Modulator fault routing, converter feed supervision and test readouts
//
// Function
// - Data, uplink power and test faults: code 0..3 drives none, A, B, both.
// - Clock fault 0..3 like data; 4..7 all-ones plus none, A, B, both.
// - Converter power fault codes 0..3 drive none, A, B, both, no mute.
// - Converter power fault codes 4..7 mute plus none, A, B, both.
// - Feed voltage below configured minimum, up to 60 V, raises power fault.
// - Feed current above configured maximum, up to 6 A, raises power fault.
// - Feed current below configured minimum, up to 4 A, raises power fault.
// - One setting bit switches converter power feed off or on.
// - One setting bit withholds or supplies frequency reference to converter.
// - Nonzero converter oscillator setting makes transmit frequency an RF value.
// - Two-bit test field: normal, pure carrier, alternating 1/0, sideband.
// - Read-only symbol rate computed from bit rate and coding settings.
// - Read-only bit-rate clock error measurement.
// - Selected non-internal clock absent falls back to internal clock.
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module mod_alarm_routing
  import mod_alarm_pkg::*;
#(
  parameter int MEAS_WIN = 100000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // Fault sources and feed measurement
  input wire faults_t faults,
  input wire feedMeas_t feedMeas,
  // Clock presence and bit tick of the transmit clock
  input wire logic ttClkPresent,
  input wire logic extClkPresent,
  input wire logic rcvClkPresent,
  input wire logic bitTick,
  // Alarm and converter outputs
  output alarmReq_t alarmOut,
  output logic feedOn,
  output logic refOn,
  output logic rfFreqMode,
  output testMode_t testMode,
  output clkSrc_t txClkSel
);

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic alarmReq_t route2(input logic [1:0] code, input logic active,
                                       input logic mute);
    alarmReq_t r;
    r.alarmA = active & code[0];
    r.alarmB = active & code[1];
    r.mute = active & mute;
    r.allOnes = 1'b0;
    return r;
  endfunction

  // Oversize limits saturate rather than wrap to a small value
  function automatic logic [9:0] sat(input logic [31:0] v, input logic [9:0] lim);
    logic [9:0] r;
    r = (v > {22'h000000, lim}) ? lim : v[9:0];
    return r;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  ctrl_t ctrl_q;
  route_t route_q;
  logic [9:0] vmin_q;
  logic [9:0] imax_q;
  logic [9:0] imin_q;
  logic [31:0] loFreq_q;
  logic [31:0] bitRate_q;
  logic [31:0] readdata_q;
  logic [31:0] symRate_q;
  logic [31:0] clkErr_q;
  logic waitreq_q;
  logic irq_q;
  logic feedOn_q;
  logic refOn_q;
  logic rfMode_q;
  logic [NUM_IRQ-1:0] irqStat_q;
  logic [NUM_IRQ-1:0] irqMask_q;
  logic [NUM_IRQ-1:0] evtPrev_q;
  alarmReq_t alarm_q;
  testMode_t testMode_q;
  clkSrc_t txClkSel_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic busReq = read | write;
  wire logic accept = busReq & ~waitreq_q;
  // Writes land only in the answer cycle
  wire logic wrEn = write & accept;
  wire logic rdStatClr = read & accept & (address == ADDR_IRQSTAT);

  // ****************************************
  // Converter feed supervision
  // ****************************************
  // voltage floor
  wire logic vLow = feedMeas.volt < vmin_q;
  wire logic iHigh = feedMeas.curr > imax_q;
  wire logic iLow = feedMeas.curr < imin_q;
  // Feed off reads zero volts; only a live feed can fault
  wire logic bucFault = ctrl_q.feedOn & (vLow | iHigh | iLow);

  // ****************************************
  // Alarm routing
  // ****************************************
  // always mute
  wire alarmReq_t reqCarrier = route2(route_q.carrier, faults.carrier, 1'b1);
  wire alarmReq_t reqHw = route2(route_q.hardware, faults.hardware, 1'b1);
  wire alarmReq_t reqData = route2(route_q.data, faults.data, 1'b0);
  wire alarmReq_t reqAupc = route2(route_q.aupc, faults.aupc, 1'b0);
  wire alarmReq_t reqTest = route2(route_q.testActive, faults.testActive, 1'b0);
  wire alarmReq_t reqBuc = route2(route_q.buc[1:0], bucFault, route_q.buc[2]);
  wire logic clkOnesCode = (route_q.clock[3:2] == 2'b01);
  wire logic clkMuteCode = (route_q.clock[3:1] == 3'b100);
  // Codes 10 to 15 route nowhere
  wire logic clkPlain = (route_q.clock[3:2] == 2'b00) | clkOnesCode;
  wire alarmReq_t reqClk = '{
    alarmA: faults.clock & (clkPlain | clkMuteCode) & route_q.clock[0],
    alarmB: faults.clock & clkPlain & route_q.clock[1],
    mute: faults.clock & clkMuteCode,
    allOnes: faults.clock & clkOnesCode
  };
  wire alarmReq_t alarmNext = reqCarrier | reqHw | reqData | reqAupc | reqTest
                              | reqBuc | reqClk;

  // ****************************************
  // Clock source fallback
  // ****************************************
  // absent clock falls back
  wire logic selPresent = (ctrl_q.clkSrc == CLK_TT) ? ttClkPresent :
                          (ctrl_q.clkSrc == CLK_EXTERNAL) ? extClkPresent :
                          (ctrl_q.clkSrc == CLK_RCV) ? rcvClkPresent : 1'b1;
  wire clkSrc_t clkSel = selPresent ? clkSrc_t'(ctrl_q.clkSrc) : CLK_INTERNAL;
  wire logic fallback = ~selPresent;

  // ****************************************
  // Interrupt events
  // ****************************************
  wire logic [NUM_IRQ-1:0] evtNow = {fallback, bucFault, alarmNext.mute,
                                     alarmNext.alarmB, alarmNext.alarmA};
  // Rising edges only; a held fault raises one event
  wire logic [NUM_IRQ-1:0] evtRise = evtNow & ~evtPrev_q;
  // Clear only what the read reported; an event in the wait cycle survives
  wire logic [NUM_IRQ-1:0] irqClr = rdStatClr ? readdata_q[NUM_IRQ-1:0] : '0;
  // Set wins over the clearing read
  wire logic [NUM_IRQ-1:0] irqStat_d = (irqStat_q & ~irqClr) | evtRise;

  // ****************************************
  // Symbol rate divider
  // ****************************************
  // Serial restoring divide: bitRate*den / (num*bitsPerSym), refreshed every 37 cycles
  // One shift per dividend bit
  localparam logic [5:0] DIV_STEPS = 6'h24;
  logic [35:0] divNum_q;
  logic [35:0] divQuo_q;
  logic [5:0] divRem_q;
  logic [5:0] divCnt_q;
  wire logic [3:0] rateDen = ctrl_q.fecOn ? {1'b0, ctrl_q.codeRate, 1'b0} + 4'h2 : 4'h1;
  wire logic [3:0] rateNum = rateDen - (ctrl_q.fecOn ? 4'h1 : 4'h0);
  wire logic [2:0] bitsSym = {1'b0, ctrl_q.modBits} + 3'h1;
  wire logic [5:0] divDen = 6'(rateNum) * 6'(bitsSym);
  wire logic [5:0] divTry = {divRem_q[4:0], divNum_q[35]};
  wire logic divFit = divTry >= divDen;
  wire logic divLoad = (divCnt_q == 6'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divNum_q <= '0;
      divQuo_q <= '0;
      divRem_q <= '0;
      divCnt_q <= '0;
      symRate_q <= '0;
    end else if (divLoad) begin
      divNum_q <= 36'(bitRate_q) * 36'(rateDen);
      divQuo_q <= '0;
      divRem_q <= '0;
      divCnt_q <= DIV_STEPS;
    end else begin
      divNum_q <= {divNum_q[34:0], 1'b0};
      divRem_q <= divFit ? 6'(divTry - divDen) : divTry;
      divQuo_q <= {divQuo_q[34:0], divFit};
      divCnt_q <= divCnt_q - 6'h01;
      if (divCnt_q == 6'h01) begin
        symRate_q <= {divQuo_q[30:0], divFit};
      end
    end
  end

  // ****************************************
  // Clock error measurement
  // ****************************************
  // Ticks in a 1 ms window times 1000 less the set bit rate, in bps
  logic [31:0] winCnt_q;
  logic [31:0] tickCnt_q;
  wire logic winEnd = (winCnt_q == 32'(MEAS_WIN - 1));
  wire logic [31:0] tickScaled = (tickCnt_q << 10) - (tickCnt_q << 4) - (tickCnt_q << 3);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      winCnt_q <= '0;
      tickCnt_q <= '0;
      clkErr_q <= '0;
    end else begin
      winCnt_q <= winEnd ? '0 : winCnt_q + 32'h1;
      tickCnt_q <= winEnd ? 32'(bitTick) : tickCnt_q + 32'(bitTick);
      // Slow clock gives a negative two's complement error
      if (winEnd) begin
        clkErr_q <= tickScaled - bitRate_q;
      end
    end
  end

  // ****************************************
  // Register write and read mux
  // ****************************************
  wire logic [31:0] statusWord = {23'h000000, txClkSel_q, rfMode_q, feedOn_q, bucFault,
                                  alarm_q};
  wire logic [31:0] rdMux =
    (address == ADDR_CTRL) ? {21'h000000, ctrl_q} :
    (address == ADDR_ROUTE) ? {15'h0000, route_q} :
    (address == ADDR_VMIN) ? {22'h000000, vmin_q} :
    (address == ADDR_IMAX) ? {22'h000000, imax_q} :
    (address == ADDR_IMIN) ? {22'h000000, imin_q} :
    (address == ADDR_LOFREQ) ? loFreq_q :
    (address == ADDR_BITRATE) ? bitRate_q :
    (address == ADDR_STATUS) ? statusWord :
    (address == ADDR_SYMRATE) ? symRate_q :
    (address == ADDR_CLKERR) ? clkErr_q :
    (address == ADDR_MEAS) ? {6'h00, feedMeas.curr, 6'h00, feedMeas.volt} :
    (address == ADDR_IRQSTAT) ? {27'h0000000, irqStat_q} :
    (address == ADDR_IRQMASK) ? {27'h0000000, irqMask_q} : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      route_q <= ROUTE_RST;
      vmin_q <= '0;
      imax_q <= IMAX_MAX;
      imin_q <= '0;
      loFreq_q <= '0;
      bitRate_q <= '0;
      irqMask_q <= '0;
    end else if (wrEn) begin
      case (address)
        ADDR_CTRL: ctrl_q <= writedata[10:0];
        ADDR_ROUTE: route_q <= writedata[16:0];
        ADDR_VMIN: vmin_q <= sat(writedata, VMIN_MAX);
        ADDR_IMAX: imax_q <= sat(writedata, IMAX_MAX);
        ADDR_IMIN: imin_q <= sat(writedata, IMIN_MAX);
        ADDR_LOFREQ: loFreq_q <= writedata;
        ADDR_BITRATE: bitRate_q <= writedata;
        ADDR_IRQMASK: irqMask_q <= writedata[NUM_IRQ-1:0];
        default: ;
      endcase
    end
  end

  // One wait state per access; read data captured while waiting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_q <= 1'b1;
      readdata_q <= '0;
    end else begin
      waitreq_q <= ~(busReq & waitreq_q);
      // Captured in the wait cycle so data stands when waitrequest drops
      if (read & waitreq_q) begin
        readdata_q <= rdMux;
      end
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= '0;
      feedOn_q <= 1'b0;
      refOn_q <= 1'b0;
      rfMode_q <= 1'b0;
      testMode_q <= TEST_NORMAL;
      txClkSel_q <= CLK_INTERNAL;
    end else begin
      alarm_q <= alarmNext;
      feedOn_q <= ctrl_q.feedOn;
      refOn_q <= ctrl_q.refOn;
      rfMode_q <= (loFreq_q != 32'h00000000);
      testMode_q <= testMode_t'(ctrl_q.testMode);
      txClkSel_q <= clkSel;
    end
  end

  // Interrupt status and level output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evtPrev_q <= '0;
      irqStat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      evtPrev_q <= evtNow;
      irqStat_q <= irqStat_d;
      irq_q <= |(irqStat_d & irqMask_q);
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitreq_q;
  assign irq = irq_q;
  assign alarmOut = alarm_q;
  assign feedOn = feedOn_q;
  assign refOn = refOn_q;
  assign rfFreqMode = rfMode_q;
  assign testMode = testMode_q;
  assign txClkSel = txClkSel_q;

endmodule
`default_nettype wire
